// [verilog/curve_eval.sv]
// Purpose: programmable time-versus-current curve store and evaluator
// Assumes: APB slave, 200 MHz i_clk, async active-low reset
// Notes: curve points are not reset; load or initialise before use
`timescale 1ns/1ps
`default_nettype none
module curve_eval
  import curve_pkg::*;
#(
  parameter int NCURVES = NUM_CURVES,
  parameter int NSHAPES = NUM_SHAPES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_busy,
  output logic [31:0] o_time_ms
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_WAIT, ST_COMPOSE, ST_INIT_CALC, ST_INIT_WAIT
  } state_t;

  // Pickup multiple of grid point i, in hundredths
  function automatic logic [15:0] grid_x(input logic [6:0] i);
    logic [15:0] n;
    n = {9'h000, i};
    if (i < 7'd10) grid_x = 16'(n * 16'd5);
    else if (i == 7'd10) grid_x = 16'd48;
    else if (i < 7'd32) grid_x = 16'(16'd50 + (n - 16'd11) * 16'd2);
    else if (i < 7'd40) grid_x = 16'(16'd91 + (n - 16'd32));
    else if (i == 7'd40) grid_x = 16'd103;
    else if (i == 7'd41) grid_x = 16'd105;
    else if (i < 7'd92) grid_x = 16'(16'd110 + (n - 16'd42) * 16'd10);
    else grid_x = 16'(16'd650 + (n - 16'd92) * 16'd50);
  endfunction : grid_x

  // Lower point of the segment holding multiple m
  function automatic logic [6:0] seg_of(input logic [15:0] m);
    logic [6:0] k;
    k = 7'd0;
    for (int i = 1; i < CURVE_POINTS - 1; i++) begin
      if (m >= grid_x(7'(i))) k = 7'(i);
    end
    seg_of = k;
  endfunction : seg_of

  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v > {16'h0000, TIME_MAX_MS}) ? TIME_MAX_MS : v[15:0];
  endfunction : sat16

  div_if dv ();
  div_unit u_div (.i_clk(i_clk), .i_rst_n(i_rst_n), .d(dv));

  logic [15:0] pts_q [0:NCURVES*128-1];

  state_t state_q;
  logic [1:0] curve_q;
  logic [5:0] shape_q;
  logic floor_en_q;
  logic hc_en_q;
  logic shape_err_q;
  logic [15:0] pickup_q;
  logic [15:0] mult_q;
  logic [15:0] adder_q;
  logic [15:0] floor_q;
  logic [15:0] hc_ratio_q;
  logic [15:0] hc_time_q;
  logic [31:0] result_q;
  logic [15:0] m_q;
  logic [6:0] k_q;
  logic hold_q;
  logic [15:0] y0_q;
  logic rising_q;
  logic [15:0] t_q;
  logic [6:0] p_q;
  logic [1:0] ecurve_q;
  logic [15:0] scale_q;
  logic div_start_q;
  logic [31:0] div_num_q;
  logic [15:0] div_den_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic fsm_we;
  logic [8:0] fsm_addr;
  logic [15:0] fsm_wdata;

  // APB decode
  logic setup;
  logic access_done;
  logic in_win;
  logic [8:0] win_addr;
  logic win_ok;
  logic reg_ok;
  logic ctrl_wr;

  always_comb begin
    setup = i_psel && !i_penable;
    access_done = i_psel && i_penable && pready_q;
    in_win = i_paddr[POINT_WIN_BIT];
    win_addr = i_paddr[10:2];
    win_ok = in_win && (i_paddr[8:2] < 7'(CURVE_POINTS)) && (i_paddr[1:0] == 2'b00);
    reg_ok = !in_win && (i_paddr[1:0] == 2'b00) && (i_paddr <= RESULT_OFS);
    ctrl_wr = access_done && i_pwrite && !pslverr_q && (i_paddr == CTRL_OFS);
  end

  // Setup cycle prepares the answer; access phase completes with no wait
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        // Point writes while busy would race the fill engine, so refuse them
        pslverr_q <= !(reg_ok || win_ok) || (win_ok && i_pwrite && state_q != ST_IDLE);
        prdata_q <= 32'h00000000;
        if (win_ok && !i_pwrite) begin
          prdata_q <= {16'h0000, pts_q[win_addr]};
        end else if (reg_ok && !i_pwrite) begin
          case (i_paddr)
            CTRL_OFS: prdata_q <= {14'h0000, hc_en_q, floor_en_q, 6'h00, shape_q, curve_q, 2'b00};
            STATUS_OFS: prdata_q <= {30'h00000000, shape_err_q, state_q != ST_IDLE};
            PICKUP_OFS: prdata_q <= {16'h0000, pickup_q};
            MULT_OFS: prdata_q <= {16'h0000, mult_q};
            ADDER_OFS: prdata_q <= {16'h0000, adder_q};
            FLOOR_OFS: prdata_q <= {16'h0000, floor_q};
            HC_RATIO_OFS: prdata_q <= {16'h0000, hc_ratio_q};
            HC_TIME_OFS: prdata_q <= {16'h0000, hc_time_q};
            RESULT_OFS: prdata_q <= result_q;
            default: prdata_q <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Settings registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      curve_q <= 2'b00;
      shape_q <= 6'h00;
      floor_en_q <= 1'b0;
      hc_en_q <= 1'b0;
      pickup_q <= PICKUP_RST;
      mult_q <= MULT_RST;
      adder_q <= ADDER_RST;
      floor_q <= FLOOR_RST;
      hc_ratio_q <= HC_RATIO_RST;
      hc_time_q <= HC_TIME_RST;
    end else if (access_done && i_pwrite && !pslverr_q) begin
      case (i_paddr)
        CTRL_OFS: begin
          curve_q <= i_pwdata[CTRL_CURVE_LSB +: 2];
          shape_q <= i_pwdata[CTRL_SHAPE_LSB +: 6];
          floor_en_q <= i_pwdata[CTRL_FLOOR_EN_BIT];
          hc_en_q <= i_pwdata[CTRL_HC_EN_BIT];
        end
        PICKUP_OFS: pickup_q <= i_pwdata[15:0];
        MULT_OFS: mult_q <= i_pwdata[15:0];
        ADDER_OFS: adder_q <= i_pwdata[15:0];
        FLOOR_OFS: floor_q <= i_pwdata[15:0];
        HC_RATIO_OFS: hc_ratio_q <= i_pwdata[15:0];
        HC_TIME_OFS: hc_time_q <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Point memory: the fill engine owns it while busy
  always_comb begin
    fsm_we = 1'b0;
    fsm_addr = {ecurve_q, p_q};
    fsm_wdata = 16'h0000;
    if (state_q == ST_INIT_CALC && p_q < 7'(RESET_POINTS)) begin
      fsm_we = 1'b1;
      fsm_wdata = 16'(scale_q * 16'd4);
    end else if (state_q == ST_INIT_WAIT && dv.done) begin
      fsm_we = 1'b1;
      fsm_wdata = sat16(dv.quotient);
    end
  end

  always_ff @(posedge i_clk) begin
    if (fsm_we) begin
      pts_q[fsm_addr] <= fsm_wdata;
    end else if (access_done && i_pwrite && !pslverr_q && in_win) begin
      pts_q[win_addr] <= i_pwdata[15:0];
    end
  end

  // Evaluation and fill engine
  logic [15:0] x0;
  logic [15:0] x1;
  logic [15:0] y0;
  logic [15:0] y1;
  logic [15:0] dy;
  logic [31:0] scaled;
  logic [31:0] comp;

  always_comb begin
    x0 = grid_x(k_q);
    x1 = grid_x(7'(k_q + 7'd1));
    y0 = pts_q[{ecurve_q, k_q}];
    y1 = pts_q[{ecurve_q, 7'(k_q + 7'd1)}];
    dy = (y1 >= y0) ? 16'(y1 - y0) : 16'(y0 - y1);
    scaled = 32'(({16'h0000, t_q} * {16'h0000, mult_q}) >> MULT_FRAC_BITS);
    comp = scaled + {16'h0000, adder_q};
    if (floor_en_q && comp < {16'h0000, floor_q}) comp = {16'h0000, floor_q};
    if (hc_en_q && m_q > hc_ratio_q) comp = {16'h0000, hc_time_q};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      m_q <= 16'h0000;
      k_q <= 7'd0;
      hold_q <= 1'b0;
      y0_q <= 16'h0000;
      rising_q <= 1'b0;
      t_q <= 16'h0000;
      p_q <= 7'd0;
      ecurve_q <= 2'b00;
      scale_q <= 16'h0000;
      result_q <= 32'h00000000;
      shape_err_q <= 1'b0;
      div_start_q <= 1'b0;
      div_num_q <= 32'h00000000;
      div_den_q <= 16'h0001;
    end else begin
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (ctrl_wr && i_pwdata[CTRL_EVAL_BIT]) begin
            m_q <= pickup_q;
            ecurve_q <= i_pwdata[CTRL_CURVE_LSB +: 2];
            hold_q <= (pickup_q >= LAST_MULT_PU);
            k_q <= (pickup_q >= LAST_MULT_PU) ? 7'(CURVE_POINTS - 1) : seg_of(pickup_q);
            state_q <= ST_LOAD;
          end else if (ctrl_wr && i_pwdata[CTRL_INIT_BIT]) begin
            // An unknown shape leaves the curve untouched and flags it
            shape_err_q <= (i_pwdata[CTRL_SHAPE_LSB +: 6] >= 6'(NSHAPES));
            if (i_pwdata[CTRL_SHAPE_LSB +: 6] < 6'(NSHAPES)) begin
              ecurve_q <= i_pwdata[CTRL_CURVE_LSB +: 2];
              scale_q <= 16'(SHAPE_SCALE_MS * (16'(i_pwdata[CTRL_SHAPE_LSB +: 6]) + 16'd1));
              p_q <= 7'd0;
              state_q <= ST_INIT_CALC;
            end
          end
        end
        ST_LOAD: begin
          if (hold_q) begin
            t_q <= y0;
            state_q <= ST_COMPOSE;
          end else begin
            y0_q <= y0;
            rising_q <= (y1 >= y0);
            div_num_q <= {16'h0000, dy} * {16'h0000, 16'(m_q - x0)};
            div_den_q <= 16'(x1 - x0);
            div_start_q <= 1'b1;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (dv.done) begin
            t_q <= rising_q ? 16'(y0_q + dv.quotient[15:0]) : 16'(y0_q - dv.quotient[15:0]);
            state_q <= ST_COMPOSE;
          end
        end
        ST_COMPOSE: begin
          // Composite shaping applies to the operate side only
          result_q <= (m_q >= MULT_UNIT_PU) ? comp : {16'h0000, t_q};
          state_q <= ST_IDLE;
        end
        ST_INIT_CALC: begin
          if (p_q < 7'(RESET_POINTS)) begin
            p_q <= 7'(p_q + 7'd1);
          end else begin
            // Simple inverse shape: scale * 1 pu / (multiple - 1 pu)
            div_num_q <= {16'h0000, scale_q} * {16'h0000, MULT_UNIT_PU};
            div_den_q <= 16'(grid_x(p_q) - MULT_UNIT_PU);
            div_start_q <= 1'b1;
            state_q <= ST_INIT_WAIT;
          end
        end
        ST_INIT_WAIT: begin
          if (dv.done) begin
            p_q <= 7'(p_q + 7'd1);
            state_q <= (p_q == 7'(CURVE_POINTS - 1)) ? ST_IDLE : ST_INIT_CALC;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign dv.start = div_start_q;
  assign dv.dividend = div_num_q;
  assign dv.divisor = div_den_q;

  // Outputs from flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state_q != ST_IDLE);
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_time_ms = result_q;
endmodule : curve_eval
`default_nettype wire

// [verilog/curve_pkg.sv]
// Purpose: shared constants for the composite inverse-time curve block
// Assumes: APB register map, word aligned, 32-bit data
// Notes: pickup multiples are unsigned hundredths of pickup (100 = 1.00)
package curve_pkg;
  localparam int NUM_CURVES = 4;
  localparam int RESET_POINTS = 40;
  localparam int OPER_POINTS = 80;
  localparam int CURVE_POINTS = 120;
  localparam int NUM_SHAPES = 41;
  localparam logic [15:0] TIME_MAX_MS = 16'hFFFF;
  localparam logic [15:0] MULT_UNIT_PU = 16'h0064;
  localparam logic [15:0] LAST_MULT_PU = 16'h07D0;
  localparam int MULT_FRAC_BITS = 8;
  localparam int DIV_STEPS = 32;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] PICKUP_OFS = 12'h008;
  localparam logic [11:0] MULT_OFS = 12'h00C;
  localparam logic [11:0] ADDER_OFS = 12'h010;
  localparam logic [11:0] FLOOR_OFS = 12'h014;
  localparam logic [11:0] HC_RATIO_OFS = 12'h018;
  localparam logic [11:0] HC_TIME_OFS = 12'h01C;
  localparam logic [11:0] RESULT_OFS = 12'h020;
  localparam int POINT_WIN_BIT = 11;
  // CTRL field positions
  localparam int CTRL_EVAL_BIT = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam int CTRL_CURVE_LSB = 2;
  localparam int CTRL_SHAPE_LSB = 4;
  localparam int CTRL_FLOOR_EN_BIT = 16;
  localparam int CTRL_HC_EN_BIT = 17;
  // STATUS field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SHAPE_ERR_BIT = 1;
  // Reset values, and the shape scale step used by the fill
  localparam logic [15:0] MULT_RST = 16'h0100;
  localparam logic [15:0] ADDER_RST = 16'h0000;
  localparam logic [15:0] FLOOR_RST = 16'h0000;
  localparam logic [15:0] HC_RATIO_RST = 16'h07D0;
  localparam logic [15:0] HC_TIME_RST = 16'h0000;
  localparam logic [15:0] PICKUP_RST = 16'h0000;
  localparam logic [15:0] SHAPE_SCALE_MS = 16'h0010;
endpackage : curve_pkg

// [verilog/div_if.sv]
// Purpose: carries a divide request and its answer between modules
// Assumes: single clock, divisor never zero
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic [31:0] quotient;
  modport master (output start, output dividend, output divisor, input done, input quotient);
  modport slave (input start, input dividend, input divisor, output done, output quotient);
endinterface : div_if
`default_nettype wire

// [verilog/div_unit.sv]
// Purpose: iterative unsigned 32 by 16 divider
// Assumes: start only while idle
// Notes: answer DIV_STEPS+1 cycles after start
`timescale 1ns/1ps
`default_nettype none
module div_unit
  import curve_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  div_if.slave d
);
  logic [16:0] rem_q;
  logic [31:0] quo_q;
  logic [15:0] den_q;
  logic [5:0] cnt_q;
  logic done_q;
  logic [16:0] trial;

  always_comb begin
    trial = {rem_q[15:0], quo_q[31]} - {1'b0, den_q};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rem_q <= 17'h00000;
      quo_q <= 32'h00000000;
      den_q <= 16'h0000;
      cnt_q <= 6'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (d.start) begin
        rem_q <= 17'h00000;
        quo_q <= d.dividend;
        den_q <= d.divisor;
        cnt_q <= 6'(DIV_STEPS);
      end else if (cnt_q != 6'h00) begin
        // Restoring step: keep the subtraction only when it does not borrow
        if (!trial[16]) begin
          rem_q <= trial;
          quo_q <= {quo_q[30:0], 1'b1};
        end else begin
          rem_q <= {rem_q[15:0], quo_q[31]};
          quo_q <= {quo_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        done_q <= (cnt_q == 6'h01);
      end
    end
  end

  assign d.done = done_q;
  assign d.quotient = quo_q;
endmodule : div_unit
`default_nettype wire

// [testbench/curve_eval_assertions.sv]
// Purpose: port-level checks for curve_eval
// Assumes: one clock, async active-low reset
// Notes: bound to the block at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module curve_eval_assertions
  import curve_pkg::*;
#(
  parameter int NCURVES = NUM_CURVES,
  parameter int NSHAPES = NUM_SHAPES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_busy,
  input wire logic [31:0] o_time_ms
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic setup;
  assign setup = i_psel && !i_penable;
  a_ready_after_setup: assert property (setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_ready_needs_sel: assert property (!i_psel |=> !o_pready)
    else $error("ready without select");
  a_bad_align: assert property (setup && (i_paddr[1:0] != 2'h0) |=> o_pslverr)
    else $error("unaligned access not refused");
  a_bad_index: assert property (setup && i_paddr[11] && (i_paddr[8:2] >= 7'h78) |=> o_pslverr)
    else $error("point index beyond grid not refused");
  a_bad_reg: assert property (setup && !i_paddr[11] && (i_paddr > 12'h020) |=> o_pslverr)
    else $error("unmapped register not refused");
  a_refused_zero: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read returned data");
  a_point_width: assert property (o_pready && !i_pwrite && i_paddr[11] |-> o_prdata[31:16] == 16'h0)
    else $error("point read wider than 16 bits");
  a_eval_starts: assert property (setup && i_pwrite && (i_paddr == CTRL_OFS) && i_pwdata[0] && !o_busy
    |-> ##[1:4] o_busy)
    else $error("evaluation did not start");
  a_result_quiet: assert property ($changed(o_time_ms) |-> o_busy || $past(o_busy))
    else $error("result changed while idle");
  c_eval: cover property ($rose(o_busy));
  c_refuse: cover property (o_pready && o_pslverr);
  c_write: cover property (o_pready && i_pwrite && !o_pslverr);
endmodule : curve_eval_assertions
bind curve_eval curve_eval_assertions #(.NCURVES(NCURVES), .NSHAPES(NSHAPES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_busy(o_busy), .o_time_ms(o_time_ms)
);
`default_nettype wire

// [testbench/curve_eval_tb.sv]
// Purpose: self-checking bench for curve_eval over APB
// Assumes: point memory is loaded by the bench before use
// Notes: expected times are worked by hand from the loaded points
`timescale 1ns/1ps
`default_nettype none
module curve_eval_tb
  import curve_pkg::*;
;
  localparam logic [31:0] RV [9] = '{0, 0, 0, 32'h100, 0, 0, 32'h7D0, 0, 0};
  localparam logic [31:0] FE = 32'h1 << CTRL_FLOOR_EN_BIT;
  localparam logic [31:0] HE = 32'h1 << CTRL_HC_EN_BIT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [31:0] time_ms;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  curve_eval dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_busy(busy), .o_time_ms(time_ms)
  );
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0h want %0h", $time, m, got, exp);
    end
  endtask : chk
  // Request held until ready is sampled; the block never inserts wait states
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1);
    chk(32'(k), 32'h1, "access wait states");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic xe, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
    chk({31'h0, e}, {31'h0, xe}, m);
  endtask : rdc
  function automatic logic [11:0] pa(input int c, input int i);
    return 12'h800 + 12'(c * 512 + i * 4);
  endfunction : pa
  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 6) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (busy !== 1'b0 && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, busy}, 32'h0, "busy stuck");
  endtask : wait_idle
  task automatic ev(input int c, input logic [15:0] pu, input logic [31:0] en,
                    input logic [31:0] x);
    wr(PICKUP_OFS, {16'h0, pu});
    wr(CTRL_OFS, en | 32'(c << CTRL_CURVE_LSB) | 32'h1);
    wait_idle(200);
    chk(time_ms, x, "time output");
    rdc(RESULT_OFS, x, 1'b0, "result reg");
  endtask : ev
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  initial begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(12'(i * 4), RV[i], 1'b0, "reset value");
    end
    rdc(12'h002, 32'h0, 1'b1, "unaligned");
    rdc(12'h024, 32'h0, 1'b1, "unmapped");
    apb(1'b1, pa(0, 120), 32'h5, r, e);
    chk({31'h0, e}, 32'h1, "index 120 write");
    rdc(pa(0, 120), 32'h0, 1'b1, "index 120 read");
    wr(pa(0, 0), 32'h0001FFFF);
    rdc(pa(0, 0), 32'h0000FFFF, 1'b0, "point width");
    wr(pa(1, 10), 32'd900);
    wr(pa(1, 11), 32'd700);
    wr(pa(1, 39), 32'd500);
    wr(pa(1, 40), 32'd510);
    wr(pa(1, 42), 32'd1000);
    wr(pa(1, 43), 32'd800);
    wr(pa(1, 119), 32'd100);
    wr(pa(2, 42), 32'd333);
    wr(pa(2, 43), 32'd333);
    rdc(pa(1, 42), 32'd1000, 1'b0, "curve kept apart");
    ev(1, 16'd49, 32'h0, 32'd800);
    ev(1, 16'd115, 32'h0, 32'd900);
    ev(2, 16'd110, 32'h0, 32'd333);
    wr(MULT_OFS, 32'h200);
    wr(ADDER_OFS, 32'd5);
    ev(1, 16'd115, 32'h0, 32'd1805);
    ev(1, 16'd2500, 32'h0, 32'd205);
    wr(FLOOR_OFS, 32'd2000);
    ev(1, 16'd115, FE, 32'd2000);
    wr(HC_RATIO_OFS, 32'd110);
    wr(HC_TIME_OFS, 32'd30);
    ev(1, 16'd115, FE | HE, 32'd30);
    ev(1, 16'd110, FE | HE, 32'd2005);
    wr(MULT_OFS, 32'h100);
    wr(ADDER_OFS, 32'h0);
    ev(1, 16'd100, 32'h0, 32'd504);
    // Out-of-range shape must leave the curve untouched and flag it
    wr(CTRL_OFS, 32'h2 | (32'd3 << CTRL_CURVE_LSB) | (32'd41 << CTRL_SHAPE_LSB));
    rdc(STATUS_OFS, 32'h2, 1'b0, "shape error");
    wr(CTRL_OFS, 32'h2 | (32'd3 << CTRL_CURVE_LSB) | (32'd40 << CTRL_SHAPE_LSB));
    apb(1'b1, pa(3, 5), 32'h7, r, e);
    chk({31'h0, e}, 32'h1, "point write while busy");
    wait_idle(8000);
    rdc(STATUS_OFS, 32'h0, 1'b0, "status after fill");
    rdc(pa(3, 5), 32'd2624, 1'b0, "fill reset point");
    ev(3, 16'd200, 32'h0, 32'd656);
    ev(3, 16'd50, 32'h0, 32'd2624);
    summarize();
  end
endmodule : curve_eval_tb
`default_nettype wire
